// ===== pfts_sequencer.sv
// Protection, power-good and turn-off sequencing of one load_converter.
// Assumes AXI4-Lite register access, measurements synchronous to clk and
// the manager master clock as a plain sampled level on masterClk.
//
// Overview of operation
// - With falling slew, turn-off delay runs from command to zero volts.
// - Pre-ramp wait is turn-off delay minus present reference over falling slew.
// - Without falling slew, the delay ends by opening both switches.
// - Reference moves one fixed step at a time; dwell sets slew.
// - Step dwell is a division of the manager master clock.
// - Voltage limits are percentages of the live setpoint.
// - Non-latching faults retry after the hiccup interval until clear.
// - Latching faults stay off until cleared or recycled, after hiccup.
// - Warnings never turn the converter off.
// - Overheat warning bit low above warn point, high below hysteresis.
// - Power-good pin low outside window of 110 and 90 or 95 percent.
// - Power-good judged only in steady state, low during transitions.
// - Power-good warning drives bit low, releases on return to window.
// - External low on the power-good pin raises the power-good warning.
// - Any fault-class protection turns the converter off.
// - Armed above prebias, current limit with undervoltage trips fast.
// - Overcurrent temperature compensation above room, can be disabled.
// - Undervoltage in steady state without overcurrent: regular turn-off.
// - Overheat fault in ramp-up or steady state: regular turn-off; restart below warn.
`timescale 1ns/1ps
`include "pfts_cfg.svh"

module pfts_sequencer
  import pfts_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES =
    `PFTS_HICCUP_MS * 1000000 / `PFTS_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pfts_axi_req_type axiReq,
  output pfts_axi_rsp_type axiRsp,
  input wire logic masterClk,
  input wire logic [8:0] vOutMeas,
  input wire logic [7:0] tempMeas,
  input wire logic iAtLimit,
  input wire logic pgIn,
  output logic pgOut,
  output logic pgOe,
  output logic switchOn,
  output logic [8:0] refLevel,
  output logic tempCompOn,
  output logic managerAlert,
  output logic ovAbove
);

  localparam pfts_state_type RESET_STATE = '{
    mode: PFTS_OFF,
    cause: PFTS_CAUSE_CMD,
    status: `PFTS_STATUS_RESET,
    setpoint: `PFTS_SETPOINT_RESET,
    riseDiv: `PFTS_RISE_DIV_RESET,
    fallDiv: `PFTS_FALL_DIV_RESET,
    offDelay: `PFTS_OFF_DELAY_RESET,
    uvPct: `PFTS_UV_PCT_RESET,
    ovPct: `PFTS_OV_PCT_RESET,
    tempCompEn: 1'b1,
    pgOe: 1'b1,
    default: '0
  };
  localparam logic [24:0] HICCUP_LAST = 25'(HICCUP_CYCLES - 1);

  pfts_state_type s;
  pfts_state_type n;

  logic mtick;
  logic [15:0] vScaled;
  logic belowUv;
  logic aboveOv;
  logic outsidePg;
  logic [15:0] pgLowPct;
  logic steady;
  logic ocCond;
  logic otCond;
  logic uvCond;
  logic [15:0] stepLen;
  logic stepDue;
  logic [24:0] rampTicks;
  logic hicDone;
  logic faultCondOk;
  logic causeBitClear;
  logic awHs;
  logic wHs;
  logic arHs;
  logic [31:0] wMerged;
  logic [4:0] swClear;
  logic goFast;
  logic goRegular;
  logic goFinish;
  logic goStart;
  pfts_cause_type newCause;

  // A rising edge of the manager clock paces every ramp step.
  assign mtick = masterClk & ~s.mclkPrev;

  // Limits scale with the live setpoint, so margining moves them too.
  assign vScaled = 16'(vOutMeas) * `PFTS_PCT_FULL;
  assign belowUv = vScaled < (16'(s.setpoint) * 16'(s.uvPct));
  assign aboveOv = vScaled > (16'(s.setpoint) * 16'(s.ovPct));
  assign pgLowPct = s.pgLowSel ? `PFTS_PG_LOW_B_PCT : `PFTS_PG_LOW_A_PCT;
  assign outsidePg = (vScaled > (16'(s.setpoint) * `PFTS_PG_HIGH_PCT)) ||
                     (vScaled < (16'(s.setpoint) * pgLowPct));
  // A setpoint move is a transition even before the mode leaves steady.
  assign steady = (s.mode == PFTS_STEADY) &&
                  (s.refLevel == s.setpoint);

  assign ocCond = s.ocArmed && iAtLimit && belowUv;
  assign otCond = tempMeas > `PFTS_TEMP_FAULT;
  assign uvCond = steady && belowUv && !ocCond;

  // A zero rising divider still advances one step per master edge.
  assign stepLen = (s.mode == PFTS_RAMP_UP) ?
                   ((s.riseDiv == 16'h0000) ? 16'h0001 : s.riseDiv) :
                   s.fallDiv;
  assign stepDue = mtick &&
                   ((17'(s.stepCnt) + 17'h00001) >= 17'(stepLen));
  // Remaining ramp time in master edges from the present reference.
  assign rampTicks = 25'(s.refLevel) * 25'(s.fallDiv);
  assign hicDone = s.hicCnt >= HICCUP_LAST;

  // No restart above the fault limit, whatever tripped the converter.
  // An overheat cause may only restart once below the warning point.
  assign faultCondOk = !otCond && ((s.cause != PFTS_CAUSE_OT) ||
                       (tempMeas < `PFTS_TEMP_WARN_SET));
  always_comb begin
    case (s.cause)
      PFTS_CAUSE_OC: causeBitClear = s.status[`PFTS_BIT_OVERCURRENT_FAULT];
      PFTS_CAUSE_UV: causeBitClear = s.status[`PFTS_BIT_UNDERVOLTAGE_FAULT];
      PFTS_CAUSE_OT: causeBitClear = s.status[`PFTS_BIT_OVERHEAT_FAULT];
      default: causeBitClear = 1'b1;
    endcase
  end

  assign awHs = axiReq.awvalid && axiRsp.awready;
  assign wHs = axiReq.wvalid && axiRsp.wready;
  assign arHs = axiReq.arvalid && axiRsp.arready;

  always_comb begin
    axiRsp.awready = !s.awTaken && !s.bvalid;
    axiRsp.wready = !s.wTaken && !s.bvalid;
    axiRsp.bvalid = s.bvalid;
    axiRsp.bresp = s.bresp;
    axiRsp.arready = !s.rvalid;
    axiRsp.rvalid = s.rvalid;
    axiRsp.rdata = s.rdata;
    axiRsp.rresp = s.rresp;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wMerged[i*8 +: 8] = s.wStrb[i] ? s.wData[i*8 +: 8] : 8'h00;
    end
  end

  always_comb begin
    n = s;
    goFast = 1'b0;
    goRegular = 1'b0;
    goFinish = 1'b0;
    goStart = 1'b0;
    newCause = s.cause;
    swClear = 5'h00;
    n.mclkPrev = masterClk;

    // Write channel: address and data may arrive in either order.
    if (awHs) begin
      n.awTaken = 1'b1;
      n.awAddr = axiReq.awaddr;
    end
    if (wHs) begin
      n.wTaken = 1'b1;
      n.wData = axiReq.wdata;
      n.wStrb = axiReq.wstrb;
    end
    if (s.bvalid && axiReq.bready) begin
      n.bvalid = 1'b0;
    end
    if (s.awTaken && s.wTaken) begin
      n.awTaken = 1'b0;
      n.wTaken = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `PFTS_RESP_OKAY;
      case (s.awAddr)
        `PFTS_ADDR_RUN_CONTROL: begin
          if (s.wStrb[0]) n.runOn = wMerged[0];
        end
        `PFTS_ADDR_OUTPUT_SETPOINT: begin
          if (s.wStrb[0]) n.setpoint[7:0] = wMerged[7:0];
          if (s.wStrb[1]) n.setpoint[8] = wMerged[8];
        end
        `PFTS_ADDR_TRACKING_SLEW_CONFIG: begin
          if (s.wStrb[0]) n.riseDiv[7:0] = wMerged[7:0];
          if (s.wStrb[1]) n.riseDiv[15:8] = wMerged[15:8];
          if (s.wStrb[2]) n.fallDiv[7:0] = wMerged[23:16];
          if (s.wStrb[3]) n.fallDiv[15:8] = wMerged[31:24];
        end
        `PFTS_ADDR_TURN_OFF_DELAY_SETTING: begin
          if (s.wStrb[0]) n.offDelay[7:0] = wMerged[7:0];
          if (s.wStrb[1]) n.offDelay[15:8] = wMerged[15:8];
        end
        `PFTS_ADDR_PROTECTION_TYPE_CONFIG: begin
          if (s.wStrb[0]) n.latchCfg = wMerged[2:0];
        end
        `PFTS_ADDR_PROTECTION_THRESHOLD_CONFIG: begin
          if (s.wStrb[0]) n.uvPct = wMerged[6:0];
          if (s.wStrb[1]) n.ovPct = wMerged[14:8];
          if (s.wStrb[2]) n.pgLowSel = wMerged[16];
        end
        `PFTS_ADDR_PROTECTION_REPORTING_CONFIG: begin
          if (s.wStrb[0]) n.reportEn = wMerged[0];
        end
        `PFTS_ADDR_CURRENT_LIMIT_SETTING: begin
          if (s.wStrb[0]) n.tempCompEn = wMerged[0];
        end
        `PFTS_ADDR_PROTECTION_STATUS_WORD: begin
          // Writing one releases a latched fault bit back to high.
          if (s.wStrb[0]) begin
            swClear[`PFTS_BIT_OVERCURRENT_FAULT] =
              wMerged[`PFTS_BIT_OVERCURRENT_FAULT];
            swClear[`PFTS_BIT_UNDERVOLTAGE_FAULT] =
              wMerged[`PFTS_BIT_UNDERVOLTAGE_FAULT];
            swClear[`PFTS_BIT_OVERHEAT_FAULT] =
              wMerged[`PFTS_BIT_OVERHEAT_FAULT];
          end
        end
        `PFTS_ADDR_SEQUENCER_MONITOR: begin
        end
        default: n.bresp = `PFTS_RESP_SLVERR;
      endcase
    end

    // Read channel answers one cycle after the address is taken.
    if (s.rvalid && axiReq.rready) begin
      n.rvalid = 1'b0;
    end
    if (arHs) begin
      n.rvalid = 1'b1;
      n.rresp = `PFTS_RESP_OKAY;
      case (axiReq.araddr)
        `PFTS_ADDR_RUN_CONTROL: n.rdata = {31'h00000000, s.runOn};
        `PFTS_ADDR_OUTPUT_SETPOINT: n.rdata = {23'h000000, s.setpoint};
        `PFTS_ADDR_TRACKING_SLEW_CONFIG: n.rdata = {s.fallDiv, s.riseDiv};
        `PFTS_ADDR_TURN_OFF_DELAY_SETTING: n.rdata = {16'h0000, s.offDelay};
        `PFTS_ADDR_PROTECTION_TYPE_CONFIG:
          n.rdata = {29'h00000000, s.latchCfg};
        `PFTS_ADDR_PROTECTION_THRESHOLD_CONFIG:
          n.rdata = {15'h0000, s.pgLowSel, 1'b0, s.ovPct, 1'b0, s.uvPct};
        `PFTS_ADDR_PROTECTION_REPORTING_CONFIG:
          n.rdata = {31'h00000000, s.reportEn};
        `PFTS_ADDR_CURRENT_LIMIT_SETTING:
          n.rdata = {31'h00000000, s.tempCompEn};
        `PFTS_ADDR_PROTECTION_STATUS_WORD: n.rdata = {27'h0000000, s.status};
        `PFTS_ADDR_SEQUENCER_MONITOR:
          n.rdata = {18'h00000, s.switchOn, 1'b0, s.mode, s.refLevel};
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = `PFTS_RESP_SLVERR;
        end
      endcase
    end

    // Sequencer: fast faults win over regular ones, commands come last.
    case (s.mode)
      PFTS_OFF: begin
        if (s.runOn && !otCond) begin
          goStart = 1'b1;
        end
      end
      PFTS_RAMP_UP, PFTS_STEADY: begin
        if (vOutMeas > s.prebias) begin
          n.ocArmed = 1'b1;
        end
        if (ocCond) begin
          goFast = 1'b1;
          newCause = PFTS_CAUSE_OC;
        end else if (otCond) begin
          goRegular = 1'b1;
          newCause = PFTS_CAUSE_OT;
        end else if (uvCond) begin
          goRegular = 1'b1;
          newCause = PFTS_CAUSE_UV;
        end else if (!s.runOn) begin
          goRegular = 1'b1;
          newCause = PFTS_CAUSE_CMD;
        end else if (s.refLevel != s.setpoint) begin
          // Any setpoint change is a transition and leaves steady state.
          n.mode = PFTS_RAMP_UP;
          if (stepDue) begin
            n.stepCnt = 16'h0000;
            n.refLevel = (s.refLevel < s.setpoint) ? s.refLevel + 9'h001 :
                         s.refLevel - 9'h001;
          end else if (mtick) begin
            n.stepCnt = s.stepCnt + 16'h0001;
          end
        end else begin
          n.mode = PFTS_STEADY;
          n.stepCnt = 16'h0000;
        end
      end
      PFTS_OFF_DELAY: begin
        if (mtick && s.offCnt != 16'h0000) begin
          n.offCnt = s.offCnt - 16'h0001;
        end
        if (ocCond) begin
          goFast = 1'b1;
          newCause = PFTS_CAUSE_OC;
        end else if (s.fallDiv != 16'h0000) begin
          // Ramp starts once the remaining delay is no more than the ramp length.
          if (25'(s.offCnt) <= rampTicks) begin
            n.mode = PFTS_RAMP_DOWN;
            n.stepCnt = 16'h0000;
          end
        end else if (s.offCnt == 16'h0000) begin
          goFinish = 1'b1;
        end
      end
      PFTS_RAMP_DOWN: begin
        if (mtick && s.offCnt != 16'h0000) begin
          n.offCnt = s.offCnt - 16'h0001;
        end
        if (ocCond) begin
          goFast = 1'b1;
          newCause = PFTS_CAUSE_OC;
        end else if (s.refLevel == 9'h000) begin
          goFinish = 1'b1;
        end else if (stepDue) begin
          n.stepCnt = 16'h0000;
          n.refLevel = s.refLevel - 9'h001;
        end else if (mtick) begin
          n.stepCnt = s.stepCnt + 16'h0001;
        end
      end
      PFTS_HICCUP: begin
        if (!hicDone) begin
          n.hicCnt = s.hicCnt + 25'h0000001;
        end
        if (!s.runOn) begin
          n.mode = PFTS_OFF;
        end else if (hicDone && faultCondOk) begin
          goStart = 1'b1;
        end
      end
      PFTS_LATCHED: begin
        if (!hicDone) begin
          n.hicCnt = s.hicCnt + 25'h0000001;
        end
        if (!s.runOn) begin
          n.recycleSeen = 1'b1;
        end
        if (hicDone && s.runOn && faultCondOk &&
            (s.recycleSeen || causeBitClear)) begin
          goStart = 1'b1;
        end
      end
      default: begin
        n.mode = PFTS_OFF;
        n.switchOn = 1'b0;
        n.refLevel = 9'h000;
      end
    endcase

    if (goStart) begin
      // Every start, first or retried, ramps with the rising settings.
      n.mode = PFTS_RAMP_UP;
      n.switchOn = 1'b1;
      n.refLevel = 9'h000;
      n.stepCnt = 16'h0000;
      n.prebias = vOutMeas;
      n.ocArmed = 1'b0;
      n.cause = PFTS_CAUSE_CMD;
    end
    if (goRegular) begin
      n.mode = PFTS_OFF_DELAY;
      n.offCnt = s.offDelay;
      n.cause = newCause;
    end
    if (goFast || goFinish) begin
      // Both switches open at once; the load sets any further decay.
      n.switchOn = 1'b0;
      n.refLevel = 9'h000;
      n.hicCnt = 25'h0000000;
      n.recycleSeen = 1'b0;
      if (goFast) begin
        n.cause = newCause;
      end
      if (!goFast && s.cause == PFTS_CAUSE_CMD) begin
        n.mode = PFTS_OFF;
      end else if (n.cause == PFTS_CAUSE_OC && s.latchCfg[0] ||
                   n.cause == PFTS_CAUSE_UV && s.latchCfg[1] ||
                   n.cause == PFTS_CAUSE_OT && s.latchCfg[2]) begin
        n.mode = PFTS_LATCHED;
      end else begin
        n.mode = PFTS_HICCUP;
      end
    end

    // Fault bits: software clear first, hardware set after, so set wins.
    n.status = s.status | swClear;
    if (ocCond) begin
      n.status[`PFTS_BIT_OVERCURRENT_FAULT] = 1'b0;
    end
    if (uvCond) begin
      n.status[`PFTS_BIT_UNDERVOLTAGE_FAULT] = 1'b0;
    end
    if (otCond) begin
      n.status[`PFTS_BIT_OVERHEAT_FAULT] = 1'b0;
    end
    // Warnings only move status and the alert; they never stop the output.
    if (tempMeas > `PFTS_TEMP_WARN_SET) begin
      n.status[`PFTS_BIT_OVERHEAT_WARNING] = 1'b0;
    end else if (tempMeas < `PFTS_TEMP_WARN_CLEAR) begin
      n.status[`PFTS_BIT_OVERHEAT_WARNING] = 1'b1;
    end
    // The pin is sensed only while released, so its own drive is ignored.
    n.status[`PFTS_BIT_OUTPUT_GOOD] =
      !(steady && (outsidePg || (!s.pgOe && !pgIn)));
    n.pgOe = !(steady && !outsidePg);
    n.alert = s.reportEn &&
              (!n.status[`PFTS_BIT_OVERHEAT_WARNING] ||
               !n.status[`PFTS_BIT_OUTPUT_GOOD]);
    n.tempComp = s.tempCompEn && (tempMeas > `PFTS_TEMP_ROOM);
    n.ovAbove = s.switchOn && aboveOv;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= RESET_STATE;
    end else begin
      s <= n;
    end
  end

  assign pgOut = 1'b0;
  assign pgOe = s.pgOe;
  assign switchOn = s.switchOn;
  assign refLevel = s.refLevel;
  assign tempCompOn = s.tempComp;
  assign managerAlert = s.alert;
  assign ovAbove = s.ovAbove;

endmodule : pfts_sequencer

// ===== pfts_cfg.svh
// Constants of the point-of-load fault and turn-off sequencer.
// Assumes a 200 MHz system clock and an AXI4-Lite window of 256 bytes.
`ifndef PFTS_CFG_SVH
`define PFTS_CFG_SVH
`define PFTS_CLK_PERIOD_NS 5
`define PFTS_HICCUP_MS 130
`define PFTS_ADDR_RUN_CONTROL 8'h00
`define PFTS_ADDR_OUTPUT_SETPOINT 8'h04
`define PFTS_ADDR_TRACKING_SLEW_CONFIG 8'h08
`define PFTS_ADDR_TURN_OFF_DELAY_SETTING 8'h0C
`define PFTS_ADDR_PROTECTION_TYPE_CONFIG 8'h10
`define PFTS_ADDR_PROTECTION_THRESHOLD_CONFIG 8'h14
`define PFTS_ADDR_PROTECTION_REPORTING_CONFIG 8'h18
`define PFTS_ADDR_CURRENT_LIMIT_SETTING 8'h1C
`define PFTS_ADDR_PROTECTION_STATUS_WORD 8'h20
`define PFTS_ADDR_SEQUENCER_MONITOR 8'h24
`define PFTS_BIT_OVERHEAT_WARNING 0
`define PFTS_BIT_OUTPUT_GOOD 1
`define PFTS_BIT_OVERCURRENT_FAULT 2
`define PFTS_BIT_UNDERVOLTAGE_FAULT 3
`define PFTS_BIT_OVERHEAT_FAULT 4
`define PFTS_STATUS_RESET 5'h1F
`define PFTS_SETPOINT_RESET 9'h050
`define PFTS_RISE_DIV_RESET 16'h0001
`define PFTS_FALL_DIV_RESET 16'h0001
`define PFTS_OFF_DELAY_RESET 16'h0100
`define PFTS_UV_PCT_RESET 7'h4B
`define PFTS_OV_PCT_RESET 7'h73
`define PFTS_TEMP_WARN_SET 8'h78
`define PFTS_TEMP_WARN_CLEAR 8'h75
`define PFTS_TEMP_FAULT 8'h82
`define PFTS_TEMP_ROOM 8'h19
`define PFTS_PCT_FULL 16'h0064
`define PFTS_PG_HIGH_PCT 16'h006E
`define PFTS_PG_LOW_A_PCT 16'h005A
`define PFTS_PG_LOW_B_PCT 16'h005F
`define PFTS_RESP_OKAY 2'h0
`define PFTS_RESP_SLVERR 2'h2
`endif

// ===== pfts_pkg.sv
// Types shared by the point-of-load fault and turn-off sequencer.
// Assumes the constants of pfts_cfg.svh are included where needed.
package pfts_pkg;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr;
    logic rready;
  } pfts_axi_req_type;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } pfts_axi_rsp_type;
  typedef enum logic [2:0] {
    PFTS_OFF, PFTS_RAMP_UP, PFTS_STEADY, PFTS_OFF_DELAY, PFTS_RAMP_DOWN,
    PFTS_HICCUP, PFTS_LATCHED
  } pfts_mode_type;
  typedef enum logic [1:0] {
    PFTS_CAUSE_CMD, PFTS_CAUSE_OC, PFTS_CAUSE_UV, PFTS_CAUSE_OT
  } pfts_cause_type;
  typedef struct packed {
    pfts_mode_type mode; pfts_cause_type cause;
    logic [8:0] refLevel; logic [15:0] stepCnt; logic [15:0] offCnt;
    logic [24:0] hicCnt; logic [8:0] prebias; logic ocArmed;
    logic recycleSeen; logic [4:0] status; logic runOn;
    logic [8:0] setpoint; logic [15:0] riseDiv; logic [15:0] fallDiv;
    logic [15:0] offDelay; logic [2:0] latchCfg; logic [6:0] uvPct;
    logic [6:0] ovPct; logic pgLowSel; logic reportEn; logic tempCompEn;
    logic awTaken; logic wTaken; logic [7:0] awAddr; logic [31:0] wData;
    logic [3:0] wStrb; logic bvalid; logic [1:0] bresp; logic rvalid;
    logic [31:0] rdata; logic [1:0] rresp; logic mclkPrev;
    logic switchOn; logic pgOe; logic alert; logic ovAbove;
    logic tempComp;
  } pfts_state_type;
endpackage : pfts_pkg

// ===== pfts_manager_model.sv
// Manager-side model: master clock source and pulled-up power-good wire.
// Assumes the sequencer clock drives clk.
`timescale 1ns/1ps
module pfts_manager_model #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic pgOe,
  input wire logic extLow,
  output logic masterClk,
  output logic pgIn
);
  int cnt = 0;
  // The open-drain wire idles high through its pull-up.
  assign pgIn = !(pgOe || extLow);
  // Low for DIV system clocks, then high for DIV, from one counter.
  assign masterClk = (cnt >= DIV);
  always @(posedge clk) begin
    cnt <= (cnt == 2 * DIV - 1) ? 0 : cnt + 1;
  end
endmodule : pfts_manager_model

// ===== pfts_properties.sv
// Port checker of the sequencer, bound into every instance of it.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
module pfts_checker
  import pfts_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pfts_axi_req_type axiReq,
  input wire pfts_axi_rsp_type axiRsp,
  input wire logic masterClk,
  input wire logic [7:0] tempMeas,
  input wire logic pgOe,
  input wire logic switchOn,
  input wire logic [8:0] refLevel,
  input wire logic tempCompOn,
  input wire logic ovAbove
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A drop straight to zero opens both switches, so it is not a step.
  sequence stepMove;
    $changed(refLevel) && refLevel != 9'h000;
  endsequence
  sequence hotOff;
    tempMeas > 8'h82 ##1 tempMeas > 8'h82 && !switchOn;
  endsequence
  sequence readWait;
    axiRsp.rvalid && !axiReq.rready;
  endsequence
  AST_ONE_STEP: assert property (stepMove |->
    refLevel == $past(refLevel) + 9'h001 ||
    refLevel == $past(refLevel) - 9'h001) else $error("ref jumped");
  AST_STEP_ON_TICK: assert property (
    !$rose(masterClk) ##1 !$rose(masterClk) |=> not stepMove)
    else $error("ref moved without a master tick");
  AST_PG_IN_RAMP: assert property (stepMove |-> pgOe)
    else $error("power good released while ramping");
  AST_PG_SWITCH: assert property (
    !pgOe |-> switchOn || $past(switchOn)) else $error("good while off");
  AST_COMP_COLD: assert property (
    tempMeas <= 8'h19 ##1 tempMeas <= 8'h19 |-> !tempCompOn)
    else $error("compensation at room temperature");
  AST_HOT_NO_START: assert property (hotOff |=> !switchOn)
    else $error("start while overheated");
  AST_OV_SWITCH: assert property (
    ovAbove |-> switchOn || $past(switchOn)) else $error("ov while off");
  AST_READ_HOLDS: assert property (
    readWait |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped");
endmodule : pfts_checker
bind pfts_sequencer pfts_checker #(.HICCUP_CYCLES(HICCUP_CYCLES))
  pfts_checker_i (.clk(clk), .rst_n(rst_n), .axiReq(axiReq),
  .axiRsp(axiRsp), .masterClk(masterClk), .tempMeas(tempMeas),
  .pgOe(pgOe), .switchOn(switchOn), .refLevel(refLevel),
  .tempCompOn(tempCompOn), .ovAbove(ovAbove));

// ===== tb.sv
// Self-checking bench of the sequencer with a manager-side model.
// Assumes the sequencer, its checker and the manager model are compiled.
`timescale 1ns/1ps
module tb;
  import pfts_pkg::*;
  logic clk, rst_n, iAtLimit, extLow, follow, masterClk, pgIn, pgOut;
  logic pgOe, switchOn, tempCompOn, managerAlert, ovAbove;
  logic [8:0] vOutMeas, vHold, refLevel, sp;
  logic [7:0] tempMeas;
  logic [65:0] note;
  logic [65:0] expQ[$];
  pfts_axi_req_type axiReq;
  pfts_axi_rsp_type axiRsp;
  int errTotal = 0, samplesChecked = 0, ticks = 0, cyc = 0, t;
  pfts_sequencer #(.HICCUP_CYCLES(50)) pfts_sequencer_i (.clk(clk),
    .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp), .masterClk(masterClk),
    .vOutMeas(vOutMeas), .tempMeas(tempMeas), .iAtLimit(iAtLimit),
    .pgIn(pgIn), .pgOut(pgOut), .pgOe(pgOe), .switchOn(switchOn),
    .refLevel(refLevel), .tempCompOn(tempCompOn),
    .managerAlert(managerAlert), .ovAbove(ovAbove));
  pfts_manager_model #(.DIV(4)) pfts_manager_model_i (.clk(clk),
    .pgOe(pgOe), .extLow(extLow), .masterClk(masterClk), .pgIn(pgIn));
  // The load follows the reference unless a scenario pins the output.
  assign vOutMeas = follow ? refLevel : vHold;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  always @(posedge masterClk) ticks++;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) begin
    if (axiRsp.rvalid && axiReq.rready) begin
      note = expQ.pop_front();
      samplesChecked++;
      if ({axiRsp.rresp, axiRsp.rdata & note[63:32]} !==
          {note[65:64], note[31:0]}) begin
        errTotal++;
        $display("BAD read exp %h got %h", note, axiRsp.rdata);
      end
    end
  end
  task automatic chk(input logic ok);
    samplesChecked++;
    if (ok !== 1'b1) begin
      errTotal++;
      $display("BAD timing exp 1 got %b", ok);
    end
  endtask : chk
  function automatic logic near(input int d, input int e);
    return d >= e - 2 && d <= e + 2;
  endfunction : near
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (axiRsp.awready) aw = 1'b0;
      if (axiRsp.wready) w = 1'b0;
      axiReq.awvalid <= aw;
      axiReq.wvalid <= w;
    end while (!axiRsp.bvalid);
    axiReq.bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m = '1, input logic [1:0] r = 2'h0);
    expQ.push_back({r, m, d});
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    do @(posedge clk); while (!axiRsp.arready);
    axiReq.arvalid <= 1'b0;
    // Accept one cycle late so the held read data is exercised.
    @(posedge clk);
    axiReq.rready <= 1'b1;
    do @(posedge clk); while (!axiRsp.rvalid);
    axiReq.rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  // A reference of 9'h100 is beyond any setpoint used and means any level.
  task automatic waitFor(input logic sw, input logic [8:0] r);
    int n;
    for (n = 0; n < 9000 && !(switchOn === sw &&
         (refLevel === r || r === 9'h100)); n++) @(posedge clk);
    chk(n < 9000);
  endtask : waitFor
  task automatic outAt(input logic [8:0] v, input logic [31:0] st);
    vHold <= v;
    follow <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h20, st);
    follow <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : outAt
  task automatic endSim;
    if (errTotal == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : endSim
  initial begin
    #400000;
    errTotal++;
    endSim();
  end
  initial begin
    void'($urandom(32'h13003ccd));
    {rst_n, iAtLimit, extLow, vHold} = '0;
    axiReq = '0;
    axiReq.wstrb = 4'hF;
    follow = 1'b1;
    tempMeas = 8'h14;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h04, 32'h50);
    rd(8'h08, 32'h10001);
    rd(8'h0C, 32'h100);
    rd(8'h14, 32'h734B);
    rd(8'h20, 32'h1F);
    rd(8'h1C, 32'h1);
    rd(8'h40, 32'h0, '1, 2'h2);
    sp = 9'h010 + 9'($urandom_range(15));
    wr(8'h04, 32'(sp));
    wr(8'h0C, 32'h40);
    wr(8'h00, 32'h1);
    waitFor(1'b1, sp);
    repeat (8) @(posedge clk);
    rd(8'h24, 32'h2400 | 32'(sp));
    rd(8'h20, 32'h1F);
    wr(8'h18, 32'h1);
    tempMeas <= 8'h7D;
    repeat (3) @(posedge clk);
    rd(8'h20, 32'h1E);
    chk(managerAlert === 1'b1);
    chk(tempCompOn === 1'b1);
    rd(8'h24, 32'h2400 | 32'(sp));
    tempMeas <= 8'h76;
    rd(8'h20, 32'h1E);
    tempMeas <= 8'h73;
    repeat (2) @(posedge clk);
    rd(8'h20, 32'h1F);
    chk(managerAlert === 1'b0);
    chk(pgOut === 1'b0);
    outAt(9'(sp * 6 / 5), 32'h1D);
    outAt(9'(sp * 17 / 20), 32'h1D);
    outAt(9'((sp * 95 - 1) / 100), 32'h1F);
    wr(8'h14, 32'h1734B);
    outAt(9'((sp * 95 - 1) / 100), 32'h1D);
    extLow <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h20, 32'h1D);
    extLow <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h20, 32'h1F);
    follow <= 1'b0;
    vHold <= 9'(sp / 2);
    repeat (4) @(posedge clk);
    rd(8'h20, 32'h0, 32'h8);
    rd(8'h24, 32'h2600 | 32'(sp));
    waitFor(1'b0, 9'h000);
    t = cyc;
    waitFor(1'b1, 9'h100);
    chk(cyc - t >= 50);
    follow <= 1'b1;
    waitFor(1'b1, sp);
    rd(8'h20, 32'h0, 32'h8);
    wr(8'h20, 32'h8);
    rd(8'h20, 32'h1F);
    t = ticks;
    wr(8'h00, 32'h0);
    waitFor(1'b1, sp - 9'h001);
    chk(near(ticks - t, 65 - sp));
    waitFor(1'b0, 9'h000);
    chk(near(ticks - t, 64));
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1);
    waitFor(1'b1, sp);
    t = ticks;
    wr(8'h00, 32'h0);
    waitFor(1'b0, 9'h100);
    chk(near(ticks - t, 64));
    wr(8'h08, 32'h10001);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h1);
    waitFor(1'b1, sp);
    repeat (8) @(posedge clk);
    follow <= 1'b0;
    iAtLimit <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h24, 32'h0, 32'h21FF);
    rd(8'h20, 32'h8, 32'hC);
    iAtLimit <= 1'b0;
    follow <= 1'b1;
    repeat (200) @(posedge clk);
    rd(8'h24, 32'hC00, 32'h2E00);
    wr(8'h20, 32'h4);
    waitFor(1'b1, sp);
    rd(8'h20, 32'h1F);
    tempMeas <= 8'h87;
    repeat (4) @(posedge clk);
    rd(8'h20, 32'h0, 32'h11);
    waitFor(1'b0, 9'h000);
    tempMeas <= 8'h7D;
    repeat (200) @(posedge clk);
    rd(8'h24, 32'h0, 32'h2000);
    tempMeas <= 8'h76;
    waitFor(1'b1, sp);
    rd(8'h24, 32'h2400 | 32'(sp));
    endSim();
  end
endmodule : tb
